// *** rtl/usart_spi.sv ***
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module usart_spi
    import usart_spi_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter bit SECOND_INSTANCE = 1'b0
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Auxiliary clock as a one-cycle tick
    input wire logic AUX_CLK_TICK,
    // Serial clock pin
    input wire logic SPI_SERIAL_CLOCK_I,
    output logic SPI_SERIAL_CLOCK_O,
    output logic SPI_SERIAL_CLOCK_OE,
    // Master-out data pin
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    // Master-in data pin
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    // Slave-select pin, active low
    input wire logic SLAVE_SELECT_PIN_N
);

    // ************************************************************
    // Register state
    // ************************************************************
    control_s control_reg;
    logic [7:1] tx_control_reg;
    logic conflict_reg;
    logic overrun_reg;
    logic [7:0] divisor_low_reg;
    logic [7:0] divisor_high_reg;
    logic [7:0] modulation_reg;
    logic [7:0] rx_buffer_reg;
    logic [7:0] tx_buffer_reg;
    logic tx_full_reg;
    logic [7:0] module_en_one_reg;
    logic [7:0] module_en_two_reg;
    logic [7:0] irq_en_one_reg;
    logic tx_irq_reg;
    logic rx_irq_reg;
    logic [31:0] rdata_reg;
    logic ready_reg;
    logic slverr_reg;

    // ************************************************************
    // Engine state
    // ************************************************************
    xfer_state_e state_reg;
    logic sclk_level_reg;
    logic [15:0] div_cnt_reg;
    logic [4:0] edge_cnt_reg;
    logic lead_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] rx_shift_reg;
    logic data_out_reg;
    logic ss_prev_reg;
    logic sclk_prev_reg;
    logic sclk_oe_reg;
    logic mosi_oe_reg;
    logic miso_oe_reg;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [3:0] idx;
    logic mapped;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign idx = PADDR[5:2];
    assign mapped = (PADDR[ADDR_W-1:6] == '0) && (PADDR[1:0] == 2'h0) && (idx <= IDX_IRQ_FLAGS);
    assign access = PSEL && PENABLE && ready_reg;
    assign wr_fire = access && PWRITE && mapped;
    assign rd_fire = access && !PWRITE && mapped;
    assign wbyte = PWDATA[7:0];

    // ************************************************************
    // Mode and engine decode
    // ************************************************************
    logic spi_on;
    logic four_pin;
    logic ss_active;
    logic master_block;
    logic [1:0] src_sel;
    logic bitrate_source_clock_tick;
    logic [15:0] divisor;
    logic [15:0] half_div;
    logic master_edge;
    logic slave_edge;
    logic sclk_edge;
    logic capture;
    logic change;
    logic [4:0] nbits;
    logic last_edge;
    logic rx_done;
    logic master_start;
    logic slave_load;
    logic load;
    logic rx_in;
    logic abort;
    logic tx_empty;
    logic [7:0] rx_char;

    // Enable comes from this instance's module enable bit
    assign spi_on = (SECOND_INSTANCE ? module_en_two_reg[POS_SPI_EN_SECOND]
                                     : module_en_one_reg[POS_SPI_EN_FIRST])
                    && control_reg.sync && !control_reg.soft_reset;
    assign four_pin = !tx_control_reg[POS_SS_CONTROL];
    assign ss_active = !four_pin || !SLAVE_SELECT_PIN_N;
    // A low select in 4-pin master mode means another master owns the bus
    assign master_block = control_reg.master && four_pin && !SLAVE_SELECT_PIN_N;
    assign src_sel = tx_control_reg[POS_SRC_HI:POS_SRC_LO];
    // Sub-main clock is the system clock itself, so it ticks every cycle
    assign bitrate_source_clock_tick = (src_sel == SRC_AUX) ? AUX_CLK_TICK : src_sel[1];
    assign divisor = {divisor_high_reg, divisor_low_reg};
    assign half_div = {1'b0, divisor[15:1]};

    // Two serial clock edges per divisor period; divisors below two are undefined
    assign master_edge = control_reg.master && (state_reg == ST_SHIFT) && bitrate_source_clock_tick && !master_block
                         && ((div_cnt_reg == half_div - 16'h0001) || (div_cnt_reg == divisor - 16'h0001));
    assign slave_edge = !control_reg.master && ss_active && (SPI_SERIAL_CLOCK_I != sclk_prev_reg);
    assign sclk_edge = spi_on && (control_reg.master ? master_edge : slave_edge);
    assign capture = sclk_edge && (tx_control_reg[POS_PHASE] ? lead_reg : !lead_reg);
    assign change = sclk_edge && !capture;
    assign nbits = control_reg.char8 ? BITS_EIGHT : BITS_SEVEN;
    assign last_edge = edge_cnt_reg == {nbits[3:0], 1'b0} - 5'h01;
    assign rx_done = capture && ({1'b0, edge_cnt_reg[4:1]} == nbits - 5'h01);

    assign master_start = control_reg.master && (state_reg == ST_IDLE) && tx_full_reg && spi_on
                          && !master_block && (src_sel != SRC_EXTERNAL);
    assign slave_load = !control_reg.master && (state_reg == ST_IDLE) && tx_full_reg && spi_on;
    assign load = master_start || slave_load;
    assign abort = control_reg.soft_reset || (!control_reg.master && !ss_active);

    // Loopback takes our own output in place of the pin
    assign rx_in = control_reg.listen ? data_out_reg
                 : (control_reg.master ? MISO_I : MOSI_I);
    assign rx_char = control_reg.char8 ? {rx_shift_reg[6:0], rx_in}
                                       : {1'b0, rx_shift_reg[5:0], rx_in};
    assign tx_empty = !tx_full_reg && (state_reg == ST_IDLE);

    // ************************************************************
    // APB answer: one wait state, then data and error
    // ************************************************************
    always_comb begin
        rbyte = 8'h00;
        unique case (idx)
            IDX_CONTROL: rbyte = {control_reg.spare, 1'b0, control_reg.char8, control_reg.listen,
                                  control_reg.sync, control_reg.master, control_reg.soft_reset};
            IDX_TX_CONTROL: rbyte = {tx_control_reg, tx_empty};
            IDX_RX_CONTROL: rbyte = {conflict_reg, 1'b0, overrun_reg, 5'h00};
            IDX_MODULATION: rbyte = modulation_reg;
            IDX_DIVISOR_LOW: rbyte = divisor_low_reg;
            IDX_DIVISOR_HIGH: rbyte = divisor_high_reg;
            IDX_RX_BUFFER: rbyte = rx_buffer_reg;
            IDX_TX_BUFFER: rbyte = tx_buffer_reg;
            IDX_MODULE_EN_ONE: rbyte = module_en_one_reg;
            IDX_MODULE_EN_TWO: rbyte = module_en_two_reg;
            IDX_IRQ_EN_ONE: rbyte = irq_en_one_reg;
            IDX_IRQ_FLAGS: rbyte = {tx_irq_reg, rx_irq_reg, 6'h00};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ready_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            slverr_reg <= 1'b0;
        end else begin
            ready_reg <= PSEL && PENABLE && !ready_reg;
            rdata_reg <= {24'h000000, (mapped ? rbyte : 8'h00)};
            slverr_reg <= PSEL && PENABLE && !ready_reg && !mapped;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            control_reg <= control_s'({CONTROL_RST[7:6], CONTROL_RST[4:0]});
            tx_control_reg <= TX_CONTROL_RST[7:1];
            divisor_low_reg <= BYTE_RST;
            divisor_high_reg <= BYTE_RST;
            modulation_reg <= BYTE_RST;
            module_en_one_reg <= BYTE_RST;
            module_en_two_reg <= BYTE_RST;
        end else if (wr_fire) begin
            unique case (idx)
                IDX_CONTROL: control_reg <= {wbyte[7:6], wbyte[4:0]};
                IDX_TX_CONTROL: tx_control_reg <= wbyte[7:1];
                IDX_DIVISOR_LOW: divisor_low_reg <= wbyte;
                IDX_DIVISOR_HIGH: divisor_high_reg <= wbyte;
                IDX_MODULATION: modulation_reg <= wbyte;
                IDX_MODULE_EN_ONE: module_en_one_reg <= wbyte;
                IDX_MODULE_EN_TWO: module_en_two_reg <= wbyte;
                default: ;
            endcase
        end
    end

    // The transmit and receive interrupt enables (bits 7:6) are dropped while soft reset is held; a write in the same cycle wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_en_one_reg <= BYTE_RST;
        end else if (wr_fire && idx == IDX_IRQ_EN_ONE) begin
            irq_en_one_reg <= wbyte;
        end else if (control_reg.soft_reset) begin
            irq_en_one_reg[POS_TX_IRQ:POS_RX_IRQ] <= 2'h0;
        end
    end

    // ************************************************************
    // Transmit buffer and transmit flag
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_buffer_reg <= BYTE_RST;
            tx_full_reg <= 1'b0;
        end else if (control_reg.soft_reset) begin
            tx_full_reg <= 1'b0;
        end else if (wr_fire && idx == IDX_TX_BUFFER) begin
            tx_buffer_reg <= wbyte;
            tx_full_reg <= 1'b1;
        end else if (load) begin
            tx_full_reg <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_irq_reg <= 1'b1;
        end else if (control_reg.soft_reset || load) begin
            tx_irq_reg <= 1'b1;
        end else if (wr_fire && idx == IDX_TX_BUFFER) begin
            tx_irq_reg <= 1'b0;
        end else if (wr_fire && idx == IDX_IRQ_FLAGS) begin
            tx_irq_reg <= wbyte[POS_TX_IRQ];
        end
    end

    // ************************************************************
    // Receive buffer, receive flag, overrun and conflict
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_buffer_reg <= BYTE_RST;
        end else if (rx_done) begin
            rx_buffer_reg <= rx_char;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_irq_reg <= 1'b0;
        end else if (control_reg.soft_reset) begin
            rx_irq_reg <= 1'b0;
        end else if (rx_done) begin
            rx_irq_reg <= 1'b1;
        end else if (rd_fire && idx == IDX_RX_BUFFER) begin
            rx_irq_reg <= 1'b0;
        end else if (wr_fire && idx == IDX_IRQ_FLAGS) begin
            rx_irq_reg <= wbyte[POS_RX_IRQ];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            overrun_reg <= 1'b0;
        end else if (control_reg.soft_reset) begin
            overrun_reg <= 1'b0;
        end else if (rx_done && rx_irq_reg) begin
            overrun_reg <= 1'b1;
        end else if (rd_fire && idx == IDX_RX_BUFFER) begin
            overrun_reg <= 1'b0;
        end else if (wr_fire && idx == IDX_RX_CONTROL) begin
            overrun_reg <= wbyte[POS_OVERRUN];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            conflict_reg <= 1'b0;
            ss_prev_reg <= 1'b1;
        end else begin
            ss_prev_reg <= SLAVE_SELECT_PIN_N;
            if (control_reg.master && four_pin && ss_prev_reg && !SLAVE_SELECT_PIN_N) begin
                conflict_reg <= 1'b1;
            end else if (wr_fire && idx == IDX_RX_CONTROL) begin
                conflict_reg <= wbyte[POS_CONFLICT];
            end
        end
    end

    // ************************************************************
    // Transfer sequencing
    // ************************************************************
    // Clearing the enable blocks new starts and stops the serial clock edges of a transfer in progress; soft reset aborts at once
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 5'h00;
            lead_reg <= 1'b1;
        end else if (abort) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 5'h00;
            lead_reg <= 1'b1;
        end else if (master_start) begin
            state_reg <= ST_SHIFT;
            edge_cnt_reg <= 5'h00;
            lead_reg <= 1'b1;
        end else if (sclk_edge) begin
            if (last_edge) begin
                state_reg <= ST_IDLE;
                edge_cnt_reg <= 5'h00;
                lead_reg <= 1'b1;
            end else begin
                state_reg <= ST_SHIFT;
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
                lead_reg <= !lead_reg;
            end
        end
    end

    // Bit-rate divider runs on source ticks only while shifting
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_cnt_reg <= 16'h0000;
        end else if (state_reg != ST_SHIFT || !control_reg.master) begin
            div_cnt_reg <= 16'h0000;
        end else if (bitrate_source_clock_tick && !master_block) begin
            div_cnt_reg <= (div_cnt_reg >= divisor - 16'h0001) ? 16'h0000 : div_cnt_reg + 16'h0001;
        end
    end

    // Serial clock level rests at the polarity bit between characters
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sclk_level_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= SPI_SERIAL_CLOCK_I;
            if (state_reg == ST_IDLE || !control_reg.master) begin
                sclk_level_reg <= tx_control_reg[POS_POLARITY];
            end else if (sclk_edge) begin
                sclk_level_reg <= !sclk_level_reg;
            end
        end
    end

    // ************************************************************
    // Shift registers
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_shift_reg <= BYTE_RST;
            data_out_reg <= 1'b0;
        end else if (load) begin
            if (tx_control_reg[POS_PHASE]) begin
                data_out_reg <= tx_buffer_reg[7];
                tx_shift_reg <= {tx_buffer_reg[6:0], 1'b0};
            end else begin
                tx_shift_reg <= tx_buffer_reg;
            end
        end else if (change) begin
            data_out_reg <= tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_shift_reg <= BYTE_RST;
        end else if (capture) begin
            rx_shift_reg <= {rx_shift_reg[6:0], rx_in};
        end
    end

    // ************************************************************
    // Pin drive enables, registered so pins never glitch
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sclk_oe_reg <= 1'b0;
            mosi_oe_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            sclk_oe_reg <= spi_on && control_reg.master && !master_block;
            mosi_oe_reg <= spi_on && control_reg.master && !master_block;
            miso_oe_reg <= spi_on && !control_reg.master && ss_active;
        end
    end

    assign PRDATA = rdata_reg;
    assign PREADY = ready_reg;
    assign PSLVERR = slverr_reg;
    assign SPI_SERIAL_CLOCK_O = sclk_level_reg;
    assign SPI_SERIAL_CLOCK_OE = sclk_oe_reg;
    assign MOSI_O = data_out_reg;
    assign MOSI_OE = mosi_oe_reg;
    assign MISO_O = data_out_reg;
    assign MISO_OE = miso_oe_reg;

endmodule // usart_spi

// *** rtl/usart_spi_pkg.sv ***
package usart_spi_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [3:0] IDX_CONTROL = 4'h0;
    localparam logic [3:0] IDX_TX_CONTROL = 4'h1;
    localparam logic [3:0] IDX_RX_CONTROL = 4'h2;
    localparam logic [3:0] IDX_MODULATION = 4'h3;
    localparam logic [3:0] IDX_DIVISOR_LOW = 4'h4;
    localparam logic [3:0] IDX_DIVISOR_HIGH = 4'h5;
    localparam logic [3:0] IDX_RX_BUFFER = 4'h6;
    localparam logic [3:0] IDX_TX_BUFFER = 4'h7;
    localparam logic [3:0] IDX_MODULE_EN_ONE = 4'h8;
    localparam logic [3:0] IDX_MODULE_EN_TWO = 4'h9;
    localparam logic [3:0] IDX_IRQ_EN_ONE = 4'hA;
    localparam logic [3:0] IDX_IRQ_FLAGS = 4'hB;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_PHASE = 7;
    localparam int POS_POLARITY = 6;
    localparam int POS_SRC_HI = 5;
    localparam int POS_SRC_LO = 4;
    localparam int POS_SS_CONTROL = 1;
    localparam int POS_TX_EMPTY = 0;
    localparam int POS_CONFLICT = 7;
    localparam int POS_OVERRUN = 5;
    localparam int POS_SPI_EN_FIRST = 6;
    localparam int POS_SPI_EN_SECOND = 4;
    localparam int POS_TX_IRQ = 7;
    localparam int POS_RX_IRQ = 6;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [7:0] CONTROL_RST = 8'h01;
    localparam logic [7:0] TX_CONTROL_RST = 8'h01;
    localparam logic [7:0] RX_CONTROL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] SRC_EXTERNAL = 2'h0;
    localparam logic [1:0] SRC_AUX = 2'h1;
    localparam logic [4:0] BITS_SEVEN = 5'h07;
    localparam logic [4:0] BITS_EIGHT = 5'h08;

    typedef enum {ST_IDLE, ST_SHIFT} xfer_state_e;

    // Control register layout; bit 5 is not implemented
    typedef struct packed {
        logic [1:0] spare;
        logic char8;
        logic listen;
        logic sync;
        logic master;
        logic soft_reset;
    } control_s;

endpackage

// *** testbench/usart_spi_monitor.sv ***
`timescale 1ns/1ps
module usart_spi_monitor #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Serial pins
    input wire logic SPI_SERIAL_CLOCK_OE,
    input wire logic MOSI_OE,
    input wire logic SLAVE_SELECT_PIN_N
);
    logic [7:0] ctl_reg;
    logic [7:0] tc_reg;
    logic done;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    assign done = PSEL && PENABLE && PREADY;
    // Shadow of the two control bytes; soft reset leaves them alone
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl_reg <= 8'h01;
            tc_reg <= 8'h01;
        end else begin
            if (done && PWRITE && PADDR == 12'h000) ctl_reg <= PWDATA[7:0];
            if (done && PWRITE && PADDR == 12'h004) tc_reg <= PWDATA[7:0];
        end
    end
    property p_ready_wait; PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no single wait state");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_err_map; done |-> PSLVERR == (PADDR > 12'h02C || PADDR[1:0] != 2'h0); endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong");
    property p_err_data; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("error data not zero");
    property p_upper_zero; PREADY |-> PRDATA[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_ctl_bit5; done && !PWRITE && PADDR == 12'h000 |-> !PRDATA[5]; endproperty
    a_ctl_bit5: assert property (p_ctl_bit5) else $error("protocol bit set");
    property p_seven_msb; done && !PWRITE && PADDR == 12'h018 && !ctl_reg[4] |-> !PRDATA[7]; endproperty
    a_seven_msb: assert property (p_seven_msb) else $error("seven bit msb set");
    property p_release; (ctl_reg[1] && !tc_reg[1] && !SLAVE_SELECT_PIN_N) [*2] |-> !SPI_SERIAL_CLOCK_OE && !MOSI_OE;
    endproperty
    a_release: assert property (p_release) else $error("pins driven in conflict");
endmodule // usart_spi_monitor

bind usart_spi usart_spi_monitor #(.ADDR_W(ADDR_W)) mon (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SPI_SERIAL_CLOCK_OE(SPI_SERIAL_CLOCK_OE), .MOSI_OE(MOSI_OE), .SLAVE_SELECT_PIN_N(SLAVE_SELECT_PIN_N));

// *** testbench/spi_far_model.sv ***
`timescale 1ns/1ps
module spi_far_model (
    // Clock and line mode
    input wire logic CLK,
    input wire logic cpha,
    input wire logic cpol,
    // Serial wires
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Byte to answer, byte seen
    input wire logic load,
    input wire logic [7:0] tx,
    output logic [7:0] got = 8'h00
);
    logic sclk_reg = 1'b0;
    logic [8:0] sh_reg = 9'h000;
    // Far slave sampled each system clock; stale bits go out inverted
    always @(posedge CLK) begin
        sclk_reg <= sclk;
        if (load)
            sh_reg <= cpha ? {tx, ~tx[0]} : {~tx[7], tx};
        else if (sclk !== sclk_reg && ((sclk != cpol) == cpha))
            got <= {got[6:0], mosi};
        else if (sclk !== sclk_reg)
            sh_reg <= {sh_reg[7:0], ~sh_reg[0]};
    end
    assign miso = sh_reg[8];
endmodule // spi_far_model

// *** testbench/tb_usart_spi_mode_registers.sv ***
`timescale 1ns/1ps
module tb_usart_spi_mode_registers;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_n = 1'b1, mload = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] mtx = 8'h00, tc = 8'h01, rdata, toggles = 8'h00, span = 8'h00, tgt = 8'h10;
    logic rerr, sclk_q = 1'b0;
    logic pready, pslverr, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_m, sclk_w, mosi_w, miso_w;
    logic [31:0] prdata;
    logic [7:0] mgot;
    int errors = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    // Wire levels from the uut's enables
    assign sclk_w = sclk_oe ? sclk_o : tc[6];
    assign mosi_w = mosi_oe ? mosi_o : ~mosi_o;
    assign miso_w = miso_oe ? miso_o : miso_m;
    usart_spi uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .AUX_CLK_TICK(1'b0),
        .SPI_SERIAL_CLOCK_I(sclk_w), .SPI_SERIAL_CLOCK_O(sclk_o), .SPI_SERIAL_CLOCK_OE(sclk_oe), .MOSI_I(mosi_w),
        .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe),
        .SLAVE_SELECT_PIN_N(ss_n));
    spi_far_model far (.CLK(clk), .cpha(tc[7]), .cpol(tc[6]), .sclk(sclk_w), .mosi(mosi_w), .miso(miso_m),
        .load(mload), .tx(mtx), .got(mgot));
    // Serial clock edges, and cycles from first to last edge
    // Counts restart on the far side's load, so an idle-level change is not counted
    always @(posedge clk) begin
        sclk_q <= sclk_w;
        if (mload) begin
            toggles <= 8'h00;
            span <= 8'h00;
        end else begin
            if (sclk_w !== sclk_q) toggles <= toggles + 8'h01;
            if (toggles != 8'h00 && toggles < tgt) span <= span + 8'h01;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One APB transfer; request held until ready is seen
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rdata = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin errors++; final_report(); end
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdata, e);
    endtask
    // One character; far side answers t, edges expected n
    task automatic send(input logic [7:0] b, input logic [7:0] t, input logic take, input logic [7:0] n);
        int i;
        mtx <= t;
        mload <= 1'b1;
        tgt <= n;
        @(posedge clk);
        mload <= 1'b0;
        bus(1'b1, 12'h01C, b);
        rd(12'h004, tc & 8'hFE);
        i = 0;
        do begin
            bus(1'b0, 12'h004, 8'h00);
            i++;
        end while (rdata[0] !== 1'b1 && i < 100);
        if (i >= 100) begin errors++; final_report(); end
        chk(toggles, n);
        chk(span, 8'(2 * n - 2));
        chk({7'h0, sclk_o}, {7'h0, tc[6]});
        chk({6'h0, miso_oe, sclk_oe}, 8'h01);
        if (take) begin
            chk(mgot, b);
            rd(12'h018, t);
            rd(12'h02C, 8'h80);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(12'h000, 8'h01);
        rd(12'h004, 8'h01);
        rd(12'h008, 8'h00);
        rd(12'h020, 8'h00);
        rd(12'h02C, 8'h80);
        bus(1'b0, 12'h030, 8'h00);
        chk({7'h0, rerr}, 8'h01);
        bus(1'b1, 12'h000, 8'hFF);
        rd(12'h000, 8'hDF);
        bus(1'b1, 12'h00C, 8'h00);
        bus(1'b1, 12'h010, 8'h04);
        bus(1'b1, 12'h014, 8'h00);
        bus(1'b1, 12'h020, 8'h40);
        rd(12'h020, 8'h40);
        bus(1'b1, 12'h000, 8'h16);
        for (int m = 0; m < 4; m++) begin
            tc <= {m[1:0], 1'b1, m[0], 4'b0010};
            @(posedge clk);
            bus(1'b1, 12'h004, tc);
            send(8'hA1 + 8'(m), 8'h5E - 8'(m), 1'b1, 8'd16);
        end
        send(8'h3C, 8'hC3, 1'b0, 8'd16);
        send(8'h96, 8'h69, 1'b0, 8'd16);
        rd(12'h008, 8'h20);
        rd(12'h018, 8'h69);
        rd(12'h008, 8'h00);
        bus(1'b1, 12'h000, 8'h0E);
        send(8'hA4, 8'hFF, 1'b0, 8'd14);
        rd(12'h018, 8'h52);
        tc <= 8'h20;
        @(posedge clk);
        bus(1'b1, 12'h004, tc);
        ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        rd(12'h008, 8'h80);
        bus(1'b1, 12'h01C, 8'h5A);
        rd(12'h02C, 8'h00);
        ss_n <= 1'b1;
        final_report();
    end
endmodule // tb_usart_spi_mode_registers
